// File: bfc_pkg.sv
package bfc_pkg;

    // ==========================================================
    // Clock and timing
    // ==========================================================
    localparam int CLK_PERIOD_NS = 8;
    localparam int TEMP_CONV_NS = 2000;
    // Least conversion time rounds up to whole cycles
    localparam int TEMP_CONV_CYCLES = (TEMP_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // Array sizes
    // ==========================================================
    localparam int NUM_CHANNELS = 16;
    localparam int CHAN_W = 16;
    localparam int LUT_ENTRIES = 128;
    localparam int LUT_AW = 11;
    localparam int TEMP_W = 10;
    localparam int ADJ_W = 3;

    // ==========================================================
    // Register offsets (byte addresses)
    // ==========================================================
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_TEMP_TRIG = 8'h08;
    localparam logic [7:0] OFS_TEMP_CODE = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_LUT_ADDR = 8'h14;
    localparam logic [7:0] OFS_LUT_DATA = 8'h18;
    localparam logic [1:0] CHAN_WINDOW = 2'h1;

    // ==========================================================
    // Field positions and reset values
    // ==========================================================
    localparam int CTRL_CHIP_PD_BIT = 0;
    localparam int CTRL_MB_ON_BIT = 1;
    localparam int CTRL_BIAS_BIT = 2;
    localparam int CTRL_STAGE_BIT = 3;
    localparam int CTRL_SQLAW_BIT = 4;
    localparam int CTRL_LEVEL_LSB = 8;
    localparam int CTRL_SLOPE_LSB = 12;
    localparam logic [31:0] CTRL_MASK = 32'h0000_771f;
    localparam logic [31:0] CTRL_RESET = 32'h0000_440d;
    localparam int LOAD_LSB = 30;
    localparam logic [1:0] LOAD_NOW = 2'h1;
    localparam int CHAN_OFF_BIT = 12;
    localparam logic [15:0] CHAN_RESET = 16'h1000;
    localparam int TEMP_BUSY_BIT = 16;
    localparam int STAT_SINGLE_BIT = 0;
    localparam int STAT_AMP_BIT = 1;
    localparam int STAT_BEAM1_BIT = 2;
    localparam int STAT_BEAM2_BIT = 3;
    localparam int LUTA_CHAN_LSB = 8;

    // ==========================================================
    // Temperature conversion states
    // ==========================================================
    typedef enum logic [1:0] {
        TS_IDLE = 2'h1,
        TS_CONV = 2'h2
    } bfc_temp_state_t;

endpackage

// File: bfc_lut_if.sv
`timescale 1ns/1ps
// ==========================================================
// Beam-state table access
// ==========================================================
interface bfc_lut_if #(
    parameter int AW = 11,
    parameter int DW = 16
);
    logic wrEn;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;

    modport ctrl (output wrEn, output addr, output wdata, input rdata);
    modport mem (input wrEn, input addr, input wdata, output rdata);
endinterface

// File: bfc_beam_lut.sv
`timescale 1ns/1ps
// ==========================================================
// Beam-state table: entries x channels x 16-bit words
// ==========================================================
module bfc_beam_lut #(
    parameter int ENTRIES = bfc_pkg::LUT_ENTRIES,
    parameter int CHANNELS = bfc_pkg::NUM_CHANNELS
) (
    // Clock
    input wire logic core_clk,
    // Table port
    bfc_lut_if.mem lut
);
    logic [15:0] store [ENTRIES*CHANNELS];

    // Word address is entry then channel, so one entry holds a beam state
    always_ff @(posedge core_clk) begin
        if (lut.wrEn) begin
            store[lut.addr] <= lut.wdata; // RULE11 RULE12
        end
    end

    // Read-through so a read may follow an address write directly
    assign lut.rdata = store[lut.addr]; // RULE12
endmodule

// File: bfc_temp_sensor.sv
`timescale 1ns/1ps
// ==========================================================
// Temperature conversion sequencer
// ==========================================================
module bfc_temp_sensor #(
    parameter int CONV_CYCLES = bfc_pkg::TEMP_CONV_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstSync_n,
    // Control
    input wire logic start,
    input wire logic [9:0] sample,
    // Result
    output logic [9:0] code,
    output logic busy
);
    bfc_pkg::bfc_temp_state_t state_q;
    logic [15:0] cnt_q;
    logic [9:0] code_q;
    wire convDone = (state_q == bfc_pkg::TS_CONV) && (cnt_q == 16'h0);

    // One write launches a conversion; starts while busy are ignored
    always_ff @(posedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state_q <= bfc_pkg::TS_IDLE;
            cnt_q <= 16'h0;
        end else begin
            case (state_q)
                bfc_pkg::TS_IDLE: begin
                    if (start) begin
                        state_q <= bfc_pkg::TS_CONV; // RULE8
                        cnt_q <= 16'(CONV_CYCLES - 1);
                    end
                end
                bfc_pkg::TS_CONV: begin
                    if (convDone) begin
                        state_q <= bfc_pkg::TS_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 16'h1;
                    end
                end
                default: state_q <= bfc_pkg::TS_IDLE;
            endcase
        end
    end

    // Result replaced in one step only at the end of a conversion
    always_ff @(posedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            code_q <= 10'h0;
        end else if (convDone) begin
            code_q <= sample; // RULE9 RULE17
        end
    end

    assign code = code_q;
    assign busy = (state_q == bfc_pkg::TS_CONV);

    chk_code_held_between: assert property (@(posedge core_clk) disable iff (!rstSync_n)
        !convDone |=> $stable(code_q)) else $error("code changed outside conversion end"); // RULE17
    chk_conv_length: assert property (@(posedge core_clk) disable iff (!rstSync_n)
        (start && !busy) |=> busy [*2]) else $error("conversion ended too early"); // RULE8
    cov_conv_done: cover property (@(posedge core_clk) disable iff (!rstSync_n) convDone);
endmodule

// File: bfc_channel_control.sv
`timescale 1ns/1ps
// Behaviour
// [RULE1] Comes up in dual-beam operation; single-beam is an alternative setting.
// [RULE2] All even channels powered down gives single-beam, beam one output only.
// [RULE3] Even channels off leave the shared output amp on; beam two drops.
// [RULE4] Odd channels off disable the shared amp; both beam outputs drop.
// [RULE5] Bias level select 1 is nominal bias, 0 is low bias.
// [RULE6] First stage select 1 keeps first stage, 0 bypasses it.
// [RULE7] Square-law compensation enable 0 linear, 1 squared; adjusts recommended at 4.
// [RULE8] One write to the trigger register starts one temperature measurement.
// [RULE9] Measurement result is a readable 10-bit temperature code.
// [RULE10] Host reads code in standby at known temperature and keeps it.
// [RULE11] Beam-state table holds 128 addressable entries on chip.
// [RULE12] Each entry holds sixteen 16-bit channel words forming one beam state.
// [RULE13] Hard reset returns all registers and active state to defaults.
// [RULE14] Defaults: all channels off, chip powerdown 1, master bias off.
// [RULE15] Power-up raises an internal reset equal to the reset pin.
// [RULE16] Any write with load field 01 copies buffered channel settings to active.
// [RULE17] Temperature code holds until a new measurement completes, then updates whole.
module bfc_channel_control #(
    parameter int TEMP_CONV_CYCLES = bfc_pkg::TEMP_CONV_CYCLES
) (
    // Clock and resets
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic porReset_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Temperature converter sample
    input wire logic [9:0] tempSample,
    // Bias and amplifier controls
    output logic chipPowerdown,
    output logic masterBiasOn,
    output logic biasNominal,
    output logic firstStageOn,
    output logic squareLawComp,
    output logic [2:0] compLevel,
    output logic [2:0] compSlope,
    // Channel and beam state
    output logic [255:0] chanSettings,
    output logic [15:0] chanEnable,
    output logic sharedAmpOn,
    output logic beamOneActive,
    output logic beamTwoActive,
    output logic singleBeamMode
);
    localparam int NCH = bfc_pkg::NUM_CHANNELS;

    // ==========================================================
    // Decode helpers
    // ==========================================================
    function automatic logic isChanAddr(input logic [7:0] a);
        isChanAddr = (a[7:6] == bfc_pkg::CHAN_WINDOW) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [3:0] chanIdx(input logic [7:0] a);
        chanIdx = a[5:2];
    endfunction

    // ==========================================================
    // Reset release
    // ==========================================================
    logic rstMeta_q;
    logic rstSync_q;
    wire arst_n = rst_n & porReset_n; // RULE15

    // Either the pin or power-up reset clears, release is synchronised
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0; // RULE13 RULE15
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end

    default clocking defClk @(posedge core_clk);
    endclocking
    default disable iff (!rstSync_q);

    // ==========================================================
    // Temperature sample synchroniser
    // ==========================================================
    logic [9:0] tempMeta_q;
    logic [9:0] tempSync_q;

    // Sample comes from the analog converter, outside this clock
    always_ff @(posedge core_clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            tempMeta_q <= 10'h0;
            tempSync_q <= 10'h0;
        end else begin
            tempMeta_q <= tempSample;
            tempSync_q <= tempMeta_q;
        end
    end

    // ==========================================================
    // AHB-Lite address and data phase
    // ==========================================================
    logic dpValid_q;
    logic dpWrite_q;
    logic [7:0] dpAddr_q;
    logic hreadyout_q;
    logic [31:0] hrdata_q;
    wire addrOk = hsel && htrans[1] && hready;
    wire wrStb = dpValid_q && dpWrite_q;
    wire rdLast = dpValid_q && !dpWrite_q && !hreadyout_q;
    wire [7:0] wrAddr = dpAddr_q;
    wire loadNow = wrStb && (hwdata[bfc_pkg::LOAD_LSB +: 2] == bfc_pkg::LOAD_NOW);

    // Capture the address phase; reads insert one wait cycle
    always_ff @(posedge core_clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            dpValid_q <= 1'b0;
            dpWrite_q <= 1'b0;
            dpAddr_q <= 8'h0;
            hreadyout_q <= 1'b1;
        end else begin
            if (hready) begin
                dpValid_q <= addrOk;
                dpWrite_q <= hwrite;
                dpAddr_q <= haddr[7:0];
            end
            hreadyout_q <= !(addrOk && !hwrite);
        end
    end

    // ==========================================================
    // Control register
    // ==========================================================
    logic [31:0] ctrl_q;

    // Bias, stage and compensation selects come up at their defaults
    always_ff @(posedge core_clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            ctrl_q <= bfc_pkg::CTRL_RESET; // RULE13 RULE14
        end else if (wrStb && wrAddr == bfc_pkg::OFS_CTRL) begin
            ctrl_q <= hwdata & bfc_pkg::CTRL_MASK; // RULE5 RULE6 RULE7
        end
    end

    assign chipPowerdown = ctrl_q[bfc_pkg::CTRL_CHIP_PD_BIT];
    assign masterBiasOn = ctrl_q[bfc_pkg::CTRL_MB_ON_BIT];
    assign biasNominal = ctrl_q[bfc_pkg::CTRL_BIAS_BIT]; // RULE5
    assign firstStageOn = ctrl_q[bfc_pkg::CTRL_STAGE_BIT]; // RULE6
    assign squareLawComp = ctrl_q[bfc_pkg::CTRL_SQLAW_BIT]; // RULE7
    assign compLevel = ctrl_q[bfc_pkg::CTRL_LEVEL_LSB +: bfc_pkg::ADJ_W];
    assign compSlope = ctrl_q[bfc_pkg::CTRL_SLOPE_LSB +: bfc_pkg::ADJ_W];

    // ==========================================================
    // Channel settings: buffered and active copies
    // ==========================================================
    logic [15:0] chanBuf_q [NCH];
    logic [15:0] chanAct_q [NCH];
    logic [15:0] chanBuf_d [NCH];
    logic [NCH-1:0] chanOn;
    wire chanHit = wrStb && isChanAddr(wrAddr);

    // A buffered write with load 01 reaches the active copy at once
    for (genvar i = 0; i < NCH; i++) begin : g_chan
        assign chanBuf_d[i] = (chanHit && chanIdx(wrAddr) == 4'(i)) ? hwdata[15:0] : chanBuf_q[i];
        assign chanOn[i] = !chanAct_q[i][bfc_pkg::CHAN_OFF_BIT];
        assign chanSettings[i*16 +: 16] = chanAct_q[i];

        always_ff @(posedge core_clk or negedge rstSync_q) begin
            if (!rstSync_q) begin
                chanBuf_q[i] <= bfc_pkg::CHAN_RESET; // RULE13
                chanAct_q[i] <= bfc_pkg::CHAN_RESET; // RULE13 RULE14
            end else begin
                chanBuf_q[i] <= chanBuf_d[i];
                if (loadNow) begin
                    chanAct_q[i] <= chanBuf_d[i]; // RULE16
                end
            end
        end
    end

    // ==========================================================
    // Beam and shared amplifier state
    // ==========================================================
    logic [15:0] chanEnable_q;
    logic sharedAmpOn_q;
    logic beamOne_q;
    logic beamTwo_q;
    logic single_q;
    logic [7:0] oddOn;
    logic [7:0] evenOn;

    // Channel n sits at index n-1: odd channels feed beam one
    for (genvar k = 0; k < NCH / 2; k++) begin : g_beam
        assign oddOn[k] = chanOn[2*k];
        assign evenOn[k] = chanOn[2*k+1];
    end

    wire biasUp = !chipPowerdown && masterBiasOn;
    wire ampOn_d = biasUp && (|oddOn); // RULE3 RULE4
    wire single_d = (|oddOn) && !(|evenOn); // RULE1 RULE2

    // Derived state registered so every output leaves a flop
    always_ff @(posedge core_clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            chanEnable_q <= 16'h0;
            sharedAmpOn_q <= 1'b0;
            beamOne_q <= 1'b0;
            beamTwo_q <= 1'b0;
            single_q <= 1'b0;
        end else begin
            chanEnable_q <= chanOn;
            sharedAmpOn_q <= ampOn_d; // RULE3 RULE4
            beamOne_q <= ampOn_d; // RULE2
            beamTwo_q <= ampOn_d && (|evenOn); // RULE3
            single_q <= single_d; // RULE2
        end
    end

    assign chanEnable = chanEnable_q;
    assign sharedAmpOn = sharedAmpOn_q;
    assign beamOneActive = beamOne_q;
    assign beamTwoActive = beamTwo_q;
    assign singleBeamMode = single_q;

    // ==========================================================
    // Beam-state table access
    // ==========================================================
    logic [10:0] lutAddr_q;
    bfc_lut_if #(.AW(bfc_pkg::LUT_AW), .DW(bfc_pkg::CHAN_W)) lutBus ();
    wire lutWr = wrStb && wrAddr == bfc_pkg::OFS_LUT_DATA;

    // Pointer steps channel first, then entry, wrapping to zero
    always_ff @(posedge core_clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            lutAddr_q <= 11'h0;
        end else if (wrStb && wrAddr == bfc_pkg::OFS_LUT_ADDR) begin
            lutAddr_q <= {hwdata[6:0], hwdata[bfc_pkg::LUTA_CHAN_LSB +: 4]};
        end else if (lutWr) begin
            lutAddr_q <= lutAddr_q + 11'h1; // RULE11
        end
    end

    assign lutBus.wrEn = lutWr;
    assign lutBus.addr = lutAddr_q;
    assign lutBus.wdata = hwdata[15:0];

    bfc_beam_lut #(
        .ENTRIES(bfc_pkg::LUT_ENTRIES),
        .CHANNELS(NCH)
    ) u_lut (
        .core_clk(core_clk),
        .lut(lutBus.mem)
    );

    // ==========================================================
    // Temperature sensor
    // ==========================================================
    logic [9:0] tempCode;
    logic tempBusy;
    wire tempStart = wrStb && wrAddr == bfc_pkg::OFS_TEMP_TRIG; // RULE8

    bfc_temp_sensor #(
        .CONV_CYCLES(TEMP_CONV_CYCLES)
    ) u_temp (
        .core_clk(core_clk),
        .rstSync_n(rstSync_q),
        .start(tempStart),
        .sample(tempSync_q),
        .code(tempCode),
        .busy(tempBusy)
    );

    // ==========================================================
    // Read data
    // ==========================================================
    wire [31:0] rdCtrl = ctrl_q;
    wire [31:0] rdTemp = {15'h0, tempBusy, 6'h0, tempCode}; // RULE9
    wire [31:0] rdStat = {28'h0, beamTwo_q, beamOne_q, sharedAmpOn_q, single_q};
    wire [31:0] rdLutA = {20'h0, lutAddr_q[3:0], 1'b0, lutAddr_q[10:4]};
    wire [31:0] rdLutD = {16'h0, lutBus.rdata};
    wire [31:0] rdChan = {chanBuf_q[chanIdx(dpAddr_q)], chanAct_q[chanIdx(dpAddr_q)]};
    wire [31:0] rdMux =
        (dpAddr_q == bfc_pkg::OFS_CTRL) ? rdCtrl :
        (dpAddr_q == bfc_pkg::OFS_TEMP_CODE) ? rdTemp :
        (dpAddr_q == bfc_pkg::OFS_STATUS) ? rdStat :
        (dpAddr_q == bfc_pkg::OFS_LUT_ADDR) ? rdLutA :
        (dpAddr_q == bfc_pkg::OFS_LUT_DATA) ? rdLutD :
        isChanAddr(dpAddr_q) ? rdChan : 32'h0;

    // Read word latched at the end of the wait cycle
    always_ff @(posedge core_clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            hrdata_q <= 32'h0;
        end else if (rdLast) begin
            hrdata_q <= rdMux;
        end
    end

    assign hreadyout = hreadyout_q;
    assign hrdata = hrdata_q;
    assign hresp = 1'b0;

    // ==========================================================
    // Checks
    // ==========================================================
    wire [255:0] actFlat = chanSettings;

    chk_reset_defaults: assert property ($rose(rstSync_q) |->
        ctrl_q == bfc_pkg::CTRL_RESET && chanOn == 16'h0) // RULE13 RULE14
        else $error("defaults not loaded at reset release");
    chk_single_beam: assert property ((|oddOn && !(|evenOn)) |=> singleBeamMode) // RULE2
        else $error("single beam not reported");
    chk_amp_even_off: assert property ((biasUp && |oddOn && !(|evenOn)) |=>
        sharedAmpOn && beamOneActive && !beamTwoActive) // RULE3
        else $error("even powerdown disturbed amp or beam one");
    chk_amp_odd_off: assert property ((oddOn == 8'h0) |=>
        !sharedAmpOn && !beamOneActive && !beamTwoActive) // RULE4
        else $error("amp stayed on with odd channels off");
    chk_bias_written: assert property ((wrStb && wrAddr == bfc_pkg::OFS_CTRL) |=>
        biasNominal == $past(hwdata[2]) && firstStageOn == $past(hwdata[3])) // RULE5 RULE6
        else $error("bias or stage select not applied");
    chk_comp_written: assert property ((wrStb && wrAddr == bfc_pkg::OFS_CTRL) |=>
        squareLawComp == $past(hwdata[4]) && compLevel == $past(hwdata[10:8])) // RULE7
        else $error("compensation select not applied");
    chk_load_immediate: assert property ((chanHit && loadNow) |=>
        chanAct_q[chanIdx($past(wrAddr))] == $past(hwdata[15:0])) // RULE16
        else $error("load 01 did not update active channel");
    chk_buffer_only: assert property ((wrStb && !loadNow) |=> $stable(actFlat)) // RULE16
        else $error("active state changed without load");
    chk_temp_start: assert property ((tempStart && !tempBusy) |=> tempBusy) // RULE8
        else $error("trigger write did not start measurement");
    chk_read_wait: assert property ((addrOk && !hwrite) |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");

    cov_single_beam: cover property ($rose(singleBeamMode));
    cov_load_now: cover property (chanHit && loadNow);
    cov_lut_write: cover property (lutWr ##1 lutWr);
    cov_temp_read: cover property (tempStart ##[1:300] !tempBusy);
endmodule

// File: bfc_ahb_host.sv
`timescale 1ns/1ps
// ==========================================================
// Bus host: single word transfers, waits on hready
// ==========================================================
module bfc_ahb_host (
    // Clock and slave answer
    input wire logic core_clk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // Request
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    // Read result, one cycle wide
    output logic rdStrobe,
    output logic [31:0] rdData
);
    // Idle bus at time zero
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        rdStrobe = 1'b0;
        rdData = 32'h0;
    end
    // Strobe lasts one cycle
    always @(posedge core_clk) if (rdStrobe) rdStrobe <= 1'b0;
    // Address phase held until hready, then data phase held until hready
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge core_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hready !== 1'b1);
        hwdata <= ~d; // Released data shows no stale value
        if (!wr) begin
            rdData <= hrdata;
            rdStrobe <= 1'b1;
        end
    endtask
endmodule

// File: tb.sv
`timescale 1ns/1ps
// ==========================================================
// Bench top
// ==========================================================
module tb;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic porReset_n = 1'b0;
    logic [9:0] tempSample = 10'h0;
    logic [9:0] calCode, s1;
    logic hsel, hwrite, hreadyout, hresp, rdStrobe, chipPd, mbOn, biasNom, stageOn, sqLaw;
    logic ampOn, beam1, beam2, single;
    logic [1:0] htrans;
    logic [2:0] hsize, compLevel, compSlope;
    logic [15:0] chanEnable;
    logic [255:0] chanSet;
    logic [31:0] haddr, hwdata, hrdata, rdData, v;
    logic [31:0] expQ[$], mskQ[$];
    int errors = 0;
    int cmp_count = 0;
    always #4 core_clk = ~core_clk;
    bfc_ahb_host u_bfc_ahb_host (.core_clk(core_clk), .hready(hreadyout), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .rdStrobe(rdStrobe), .rdData(rdData));
    bfc_channel_control #(.TEMP_CONV_CYCLES(4)) u_bfc_channel_control (.core_clk(core_clk),
        .rst_n(rst_n), .porReset_n(porReset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .tempSample(tempSample),
        .chipPowerdown(chipPd), .masterBiasOn(mbOn), .biasNominal(biasNom),
        .firstStageOn(stageOn), .squareLawComp(sqLaw), .compLevel(compLevel),
        .compSlope(compSlope), .chanSettings(chanSet), .chanEnable(chanEnable), .sharedAmpOn(ampOn),
        .beamOneActive(beam1), .beamTwoActive(beam2), .singleBeamMode(single));
    // Comparison, verdict and bus helpers
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        expQ.push_back(e & m);
        mskQ.push_back(m);
        u_bfc_ahb_host.xfer(1'b0, a, 32'h0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_bfc_ahb_host.xfer(1'b1, a, d);
    endtask
    task automatic pins(input logic [31:0] e);
        cmp("ctrlPins", e, {17'h0, compSlope, 1'b0, compLevel, 3'h0, sqLaw, stageOn, biasNom,
            mbOn, chipPd});
    endtask
    // Every channel written with load, then beam status read
    task automatic chans(input logic [15:0] off, input logic [31:0] st);
        for (int n = 0; n < 16; n++) wr(8'h40 + 8'(4 * n), {19'h20000, off[n], 12'(n * 37)});
        rd(bfc_pkg::OFS_STATUS, st, 32'hf);
        cmp("chanEnable", {16'h0, ~off}, {16'h0, chanEnable});
        cmp("beamPins", st, {28'h0, beam2, beam1, ampOn, single});
        cmp("chanWord", {19'h0, off[15], 12'(15 * 37)}, {16'h0, chanSet[255:240]});
    endtask
    task automatic pulse_reset(input logic pin);
        if (pin) rst_n <= 1'b0;
        else porReset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        porReset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(bfc_pkg::OFS_CTRL, bfc_pkg::CTRL_RESET, 32'hffffffff);
        rd(8'h7c, 32'h10001000, 32'hffffffff);
        pins(bfc_pkg::CTRL_RESET);
        cmp("chanEnable", 32'h0, {16'h0, chanEnable});
    endtask
    // Returned words against the oldest note
    always @(posedge core_clk) if (rdStrobe === 1'b1) cmp("hrdata", expQ.pop_front(),
        rdData & mskQ.pop_front());
    // Watchdog
    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        final_report();
    end
    // Main sequence
    initial begin
        void'($urandom(32'h6e318f90));
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        porReset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(bfc_pkg::OFS_CTRL, bfc_pkg::CTRL_RESET, 32'hffffffff);
        rd(8'h44, 32'h10001000, 32'hffffffff);
        pins(bfc_pkg::CTRL_RESET);
        cmp("hresp", 32'h0, {31'h0, hresp});
        wr(8'h04, 32'hffffffff);
        rd(8'h04, 32'h0, 32'hffffffff);
        calCode = 10'($urandom);
        tempSample <= calCode;
        wr(bfc_pkg::OFS_TEMP_TRIG, 32'h0);
        repeat (14) @(posedge core_clk);
        rd(bfc_pkg::OFS_TEMP_CODE, {22'h0, calCode}, 32'h103ff);
        $display("test defaults done");
        for (int i = 0; i < 8; i++) begin
            v = ($urandom & bfc_pkg::CTRL_MASK & ~32'h1c) | 32'(i << 2);
            wr(bfc_pkg::OFS_CTRL, v);
            rd(bfc_pkg::OFS_CTRL, v, 32'hffffffff);
            pins(v);
        end
        wr(bfc_pkg::OFS_CTRL, 32'h440e);
        $display("test controls done");
        chans(16'h0, 32'he);
        chans(16'haaaa, 32'h7);
        chans(16'h5555, 32'h0);
        $display("test beams done");
        wr(8'h40, 32'h00001abc);
        rd(8'h40, 32'h1abc1000, 32'hffffffff);
        wr(8'h04, 32'h40000000);
        rd(8'h40, 32'h1abc1abc, 32'hffffffff);
        $display("test load done");
        s1 = ~calCode;
        tempSample <= s1;
        repeat (4) @(posedge core_clk);
        wr(bfc_pkg::OFS_TEMP_TRIG, 32'h0);
        rd(bfc_pkg::OFS_TEMP_CODE, {22'h0, calCode}, 32'h3ff);
        repeat (14) @(posedge core_clk);
        rd(bfc_pkg::OFS_TEMP_CODE, {22'h0, s1}, 32'h103ff);
        $display("test temperature done");
        wr(bfc_pkg::OFS_LUT_ADDR, 32'h0f7f);
        wr(bfc_pkg::OFS_LUT_DATA, 32'h5a3c);
        wr(bfc_pkg::OFS_LUT_DATA, 32'hc3a5);
        wr(bfc_pkg::OFS_LUT_ADDR, 32'h0f7f);
        rd(bfc_pkg::OFS_LUT_DATA, 32'h5a3c, 32'hffff);
        wr(bfc_pkg::OFS_LUT_ADDR, 32'h0);
        rd(bfc_pkg::OFS_LUT_DATA, 32'hc3a5, 32'hffff);
        $display("test table done");
        chans(16'h0, 32'he);
        pulse_reset(1'b1);
        wr(bfc_pkg::OFS_CTRL, 32'h440e);
        chans(16'h0, 32'he);
        pulse_reset(1'b0);
        $display("test resets done");
        final_report();
    end
endmodule
